/* File: logic/csc_pkg.sv */
`default_nettype none
package csc_pkg;

  localparam int ARP_W = 3;
  localparam int DP_W = 9;
  localparam int PM_W = 2;
  localparam int WORD_W = 16;
  localparam int ACC_W = 32;
  localparam int LOW7_W = 7;
  localparam int SHIFT_W = 5;

  // Status word zero field positions
  localparam int ARP_HI = 15;
  localparam int ARP_LO = 13;
  localparam int OV_BIT = 12;
  localparam int OVM_BIT = 11;
  localparam int RSV0_BIT = 10;
  localparam int GLOBAL_INT_MASK_BIT = 9;
  localparam int DP_HI = 8;
  localparam int DP_LO = 0;

  // Status word one field positions
  localparam int ARB_HI = 15;
  localparam int ARB_LO = 13;
  localparam int CNF_BIT = 12;
  localparam int TC_BIT = 11;
  localparam int SXM_BIT = 10;
  localparam int C_BIT = 9;
  localparam int RSVA_HI = 8;
  localparam int RSVA_LO = 5;
  localparam int XF_BIT = 4;
  localparam int RSVB_HI = 3;
  localparam int RSVB_LO = 2;
  localparam int PM_HI = 1;
  localparam int PM_LO = 0;

  localparam logic RSV0_ONES = 1'h1;
  localparam logic [3:0] RSVA_ONES = 4'hf;
  localparam logic [1:0] RSVB_ONES = 2'h3;

  typedef enum logic [2:0] {
    FLG_C = 3'h0,
    FLG_CNF = 3'h1,
    FLG_GLOBAL_INT_MASK = 3'h2,
    FLG_OVM = 3'h3,
    FLG_SXM = 3'h4,
    FLG_TC = 3'h5,
    FLG_XF = 3'h6
  } csc_flag_t;

  typedef enum logic [1:0] {
    PM_NONE = 2'h0,
    PM_LEFT1 = 2'h1,
    PM_LEFT4 = 2'h2,
    PM_RIGHT6 = 2'h3
  } csc_pm_t;

  localparam int PM_SHL1 = 1;
  localparam int PM_SHL4 = 4;
  localparam int PM_SHR6 = 6;

  localparam logic [31:0] ACC_POS_MAX = 32'h7fffffff;
  localparam logic [31:0] ACC_NEG_MAX = 32'h80000000;

  typedef struct packed {
    logic [2:0] aux_reg_pointer;
    logic [2:0] aux_pointer_buffer;
    logic ov;
    logic overflow_saturate_mode;
    logic global_int_mask;
    logic [8:0] dp;
    logic ram_map_select;
    logic tc;
    logic sign_ext_mode;
    logic c;
    logic xf;
    logic [1:0] pm;
  } csc_state_t;

  localparam csc_state_t STATE_RESET = '{
    aux_reg_pointer: 3'h0, aux_pointer_buffer: 3'h0, ov: 1'h0, overflow_saturate_mode: 1'h0, global_int_mask: 1'h1,
    dp: 9'h000, ram_map_select: 1'h0, tc: 1'h0, sign_ext_mode: 1'h1, c: 1'h1,
    xf: 1'h1, pm: 2'h0
  };

endpackage
`default_nettype wire

/* File: logic/csc_product_shift.sv */
`timescale 1ns/1ps
`default_nettype none
module csc_product_shift
  import csc_pkg::*;
(
  input wire logic [31:0] i_product,
  input wire logic [1:0] i_mode,
  output logic [31:0] o_scaled
);

  // Pure output path; the stored product is never written back
  always_comb
  begin
    unique case (csc_pm_t'(i_mode))
      PM_NONE: o_scaled = i_product;
      PM_LEFT1: o_scaled = i_product << PM_SHL1;
      PM_LEFT4: o_scaled = i_product << PM_SHL4;
      PM_RIGHT6: o_scaled = 32'($signed(i_product) >>> PM_SHR6);
    endcase
  end

endmodule
`default_nettype wire

/* File: logic/csc_input_scaler.sv */
`timescale 1ns/1ps
`default_nettype none
module csc_input_scaler
  import csc_pkg::*;
(
  input wire logic [15:0] i_data,
  input wire logic [4:0] i_shift,
  input wire logic i_sign_ext,
  output logic [31:0] o_scaled
);

  logic [31:0] extended;

  always_comb
  begin
    if (i_sign_ext)
    begin
      extended = {{WORD_W{i_data[WORD_W-1]}}, i_data};
    end
    else
    begin
      extended = {{WORD_W{1'b0}}, i_data};
    end
    o_scaled = extended << i_shift;
  end

endmodule
`default_nettype wire

/* File: logic/csc_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module csc_status_regs
  import csc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_lst_wr,
  input wire logic i_lst_sel,
  input wire logic [15:0] i_lst_data,
  output logic [15:0] o_status_word_zero,
  output logic [15:0] o_status_word_one,
  input wire logic i_set_control_flag_op,
  input wire logic i_clear_control_flag_op,
  input wire logic [2:0] i_flag_sel,
  input wire logic i_arp_load,
  input wire logic [2:0] i_arp_value,
  input wire logic i_dp_load,
  input wire logic [8:0] i_dp_value,
  input wire logic i_pm_load,
  input wire logic [1:0] i_pm_value,
  input wire logic i_c_load,
  input wire logic i_c_value,
  input wire logic i_arith_add,
  input wire logic i_arith_sub,
  input wire logic i_shift16,
  input wire logic i_carry_flag,
  input wire logic i_alu_ovf,
  input wire logic i_ov_clear,
  input wire logic i_bit_test,
  input wire logic i_tested_bit,
  input wire logic i_aux_compare,
  input wire logic i_compare_true,
  input wire logic i_acc_scale_detect_op_step,
  input wire logic [1:0] i_acc_msbs,
  input wire logic i_int_pending,
  input wire logic i_int_trap,
  output logic o_maskable_grant,
  input wire logic [31:0] i_acc_raw,
  input wire logic i_acc_overflow,
  input wire logic i_acc_ovf_positive,
  output logic [31:0] o_acc_result,
  input wire logic [31:0] i_product_register,
  output logic [31:0] o_product_scaled,
  input wire logic [15:0] i_mem_data,
  input wire logic [4:0] i_mem_shift,
  input wire logic i_add_no_sign_ext,
  output logic [31:0] o_mem_scaled,
  input wire logic [6:0] i_instr_low7,
  output logic [15:0] o_direct_addr,
  output logic [2:0] o_aux_reg_pointer,
  output logic o_ram_map_select,
  output logic o_external_flag_out
);

  csc_state_t state;
  csc_state_t next_state;
  logic bit_val;

  always_comb
  begin
    next_state = state;
    bit_val = i_set_control_flag_op;
    if (i_lst_wr)
    begin
      if (!i_lst_sel)
      begin
        // Mask bit deliberately not loaded
        next_state.aux_reg_pointer = i_lst_data[ARP_HI:ARP_LO];
        next_state.ov = i_lst_data[OV_BIT];
        next_state.overflow_saturate_mode = i_lst_data[OVM_BIT];
        next_state.dp = i_lst_data[DP_HI:DP_LO];
      end
      else
      begin
        next_state.aux_pointer_buffer = i_lst_data[ARB_HI:ARB_LO];
        next_state.aux_reg_pointer = i_lst_data[ARB_HI:ARB_LO];
        next_state.ram_map_select = i_lst_data[CNF_BIT];
        next_state.tc = i_lst_data[TC_BIT];
        next_state.sign_ext_mode = i_lst_data[SXM_BIT];
        next_state.c = i_lst_data[C_BIT];
        next_state.xf = i_lst_data[XF_BIT];
        next_state.pm = i_lst_data[PM_HI:PM_LO];
      end
    end
    if (i_set_control_flag_op || i_clear_control_flag_op)
    begin
      unique case (csc_flag_t'(i_flag_sel))
        FLG_C: next_state.c = bit_val;
        FLG_CNF: next_state.ram_map_select = bit_val;
        FLG_GLOBAL_INT_MASK: next_state.global_int_mask = bit_val;
        FLG_OVM: next_state.overflow_saturate_mode = bit_val;
        FLG_SXM: next_state.sign_ext_mode = bit_val;
        FLG_TC: next_state.tc = bit_val;
        FLG_XF: next_state.xf = bit_val;
        default: next_state = next_state;
      endcase
    end
    if (i_arp_load)
    begin
      next_state.aux_pointer_buffer = state.aux_reg_pointer;
      next_state.aux_reg_pointer = i_arp_value;
    end
    if (i_dp_load)
    begin
      next_state.dp = i_dp_value;
    end
    if (i_pm_load)
    begin
      next_state.pm = i_pm_value;
    end
    if (i_c_load)
    begin
      next_state.c = i_c_value;
    end
    // Hardware events last so a set beats a same-cycle clear
    if (i_ov_clear)
    begin
      next_state.ov = 1'b0;
    end
    if (i_alu_ovf)
    begin
      next_state.ov = 1'b1;
    end
    if (i_arith_add)
    begin
      if (!i_shift16)
      begin
        next_state.c = i_carry_flag;
      end
      else if (i_carry_flag)
      begin
        next_state.c = 1'b1;
      end
    end
    else if (i_arith_sub)
    begin
      if (!i_shift16)
      begin
        next_state.c = ~i_carry_flag;
      end
      else if (i_carry_flag)
      begin
        next_state.c = 1'b0;
      end
    end
    if (i_bit_test)
    begin
      next_state.tc = i_tested_bit;
    end
    if (i_aux_compare)
    begin
      next_state.tc = i_compare_true;
    end
    if (i_acc_scale_detect_op_step)
    begin
      next_state.tc = ^i_acc_msbs;
    end
    if (i_int_trap)
    begin
      next_state.global_int_mask = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state <= STATE_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_comb
  begin
    o_status_word_zero = {state.aux_reg_pointer, state.ov, state.overflow_saturate_mode, RSV0_ONES,
                          state.global_int_mask, state.dp};
    o_status_word_one = {state.aux_pointer_buffer, state.ram_map_select, state.tc, state.sign_ext_mode,
                         state.c, RSVA_ONES, state.xf, RSVB_ONES,
                         state.pm};
  end

  assign o_aux_reg_pointer = state.aux_reg_pointer;
  assign o_ram_map_select = state.ram_map_select;
  assign o_external_flag_out = state.xf;
  assign o_direct_addr = {state.dp, i_instr_low7};
  assign o_maskable_grant = i_int_pending & ~state.global_int_mask;

  always_comb
  begin
    if (state.overflow_saturate_mode && i_acc_overflow)
    begin
      o_acc_result = i_acc_ovf_positive ? ACC_POS_MAX : ACC_NEG_MAX;
    end
    else
    begin
      o_acc_result = i_acc_raw;
    end
  end

  csc_product_shift u_pshift (
    .i_product(i_product_register),
    .i_mode(state.pm),
    .o_scaled(o_product_scaled)
  );

  csc_input_scaler u_iscale (
    .i_data(i_mem_data),
    .i_shift(i_mem_shift),
    .i_sign_ext(state.sign_ext_mode & ~i_add_no_sign_ext),
    .o_scaled(o_mem_scaled)
  );

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  sequence seq_ptr_load;
    i_arp_load && !i_lst_wr;
  endsequence

  sequence seq_ptr_hold;
    !i_arp_load && !i_lst_wr;
  endsequence

  AST_ARB_COPY: assert property (seq_ptr_load |=>
    state.aux_pointer_buffer == $past(state.aux_reg_pointer))
    else $error("buffer missed old pointer");

  AST_ARB_HOLD: assert property (seq_ptr_load ##1 seq_ptr_hold |=>
    state.aux_pointer_buffer == $past(state.aux_reg_pointer, 2))
    else $error("buffer lost value");

  AST_LST1_ARP: assert property (i_lst_wr && i_lst_sel && !i_arp_load
    |=> state.aux_reg_pointer == state.aux_pointer_buffer &&
        state.aux_pointer_buffer == $past(i_lst_data[ARB_HI:ARB_LO]))
    else $error("word one load pointer mismatch");

  AST_RSV_ONES: assert property (o_status_word_zero[RSV0_BIT] &&
    o_status_word_one[RSVA_HI:RSVA_LO] == RSVA_ONES &&
    o_status_word_one[RSVB_HI:RSVB_LO] == RSVB_ONES)
    else $error("reserved bit reads zero");

  AST_GLOBAL_INT_MASK_LST: assert property (i_lst_wr && !i_int_trap &&
    !((i_set_control_flag_op || i_clear_control_flag_op) && i_flag_sel == FLG_GLOBAL_INT_MASK) |=> $stable(state.global_int_mask))
    else $error("status load changed mask");

  AST_GRANT: assert property (state.global_int_mask |-> !o_maskable_grant)
    else $error("masked interrupt granted");

  AST_TRAP_GLOBAL_INT_MASK: assert property (i_int_trap |=>
    state.global_int_mask && !o_maskable_grant)
    else $error("trap did not set mask");

  AST_CARRY_ADD: assert property (i_arith_add && !i_shift16 |=>
    state.c == $past(i_carry_flag))
    else $error("add carry wrong");

  AST_CARRY_SUB: assert property (!i_arith_add && i_arith_sub &&
    !i_shift16 |=> state.c == !$past(i_carry_flag))
    else $error("subtract carry wrong");

  AST_SHIFT16: assert property (i_arith_add && i_shift16 &&
    !i_carry_flag && !i_c_load && !i_lst_wr && !i_set_control_flag_op && !i_clear_control_flag_op
    |=> $stable(state.c))
    else $error("shift16 add cleared carry");

  AST_OV_STICKY: assert property (state.ov && !i_ov_clear &&
    !(i_lst_wr && !i_lst_sel) |=> state.ov)
    else $error("overflow flag dropped");

  AST_XF_PIN: assert property (i_set_control_flag_op && i_flag_sel == FLG_XF
    |=> o_external_flag_out ##1 (o_external_flag_out || $past(i_clear_control_flag_op) ||
        $past(i_lst_wr)))
    else $error("flag pin not set");

  AST_SAT: assert property (state.overflow_saturate_mode && i_acc_overflow &&
    i_acc_ovf_positive |-> o_acc_result == ACC_POS_MAX)
    else $error("positive saturation wrong");

endmodule
`default_nettype wire

/* File: bench/csc_alu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module csc_alu_model
  import csc_pkg::*;
(
  input wire logic [15:0] i_a,
  input wire logic [15:0] i_b,
  input wire logic i_sub,
  output logic o_carry
);
  logic [16:0] sum;
  // Add gives carry out, subtract gives borrow
  assign sum = i_sub ? {1'b0, i_a} - {1'b0, i_b}
                     : {1'b0, i_a} + {1'b0, i_b};
  assign o_carry = sum[16];
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import csc_pkg::*;
  logic i_mclk, i_resetn, i_lst_wr, i_lst_sel, i_set_control_flag_op, i_clear_control_flag_op, i_arp_load;
  logic i_dp_load, i_pm_load, i_c_load, i_c_value, i_arith_add, i_arith_sub;
  logic i_shift16, i_carry_flag, i_alu_ovf, i_ov_clear, i_bit_test;
  logic i_tested_bit, i_aux_compare, i_compare_true, i_acc_scale_detect_op_step;
  logic i_int_pending, i_int_trap, i_acc_overflow, i_acc_ovf_positive;
  logic i_add_no_sign_ext, o_maskable_grant, o_ram_map_select;
  logic o_external_flag_out;
  logic [1:0] i_pm_value, i_acc_msbs;
  logic [2:0] i_flag_sel, i_arp_value, o_aux_reg_pointer;
  logic [4:0] i_mem_shift;
  logic [6:0] i_instr_low7;
  logic [8:0] i_dp_value;
  logic [15:0] i_lst_data, i_mem_data, o_status_word_zero, o_status_word_one;
  logic [15:0] o_direct_addr, alu_a, alu_b;
  logic [31:0] i_acc_raw, o_acc_result, i_product_register, o_product_scaled;
  logic [31:0] o_mem_scaled;
  int error_cnt, compares;

  csc_status_regs i_csc_status_regs (
    .i_mclk, .i_resetn, .i_lst_wr, .i_lst_sel, .i_lst_data,
    .o_status_word_zero, .o_status_word_one, .i_set_control_flag_op, .i_clear_control_flag_op, .i_flag_sel,
    .i_arp_load, .i_arp_value, .i_dp_load, .i_dp_value, .i_pm_load,
    .i_pm_value, .i_c_load, .i_c_value, .i_arith_add, .i_arith_sub,
    .i_shift16, .i_carry_flag, .i_alu_ovf, .i_ov_clear, .i_bit_test,
    .i_tested_bit, .i_aux_compare, .i_compare_true, .i_acc_scale_detect_op_step,
    .i_acc_msbs, .i_int_pending, .i_int_trap, .o_maskable_grant,
    .i_acc_raw, .i_acc_overflow, .i_acc_ovf_positive, .o_acc_result,
    .i_product_register, .o_product_scaled, .i_mem_data, .i_mem_shift,
    .i_add_no_sign_ext, .o_mem_scaled, .i_instr_low7, .o_direct_addr,
    .o_aux_reg_pointer, .o_ram_map_select, .o_external_flag_out
  );

  csc_alu_model i_csc_alu_model (
    .i_a(alu_a), .i_b(alu_b), .i_sub(i_arith_sub), .o_carry(i_carry_flag)
  );

  task automatic chk(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Strobes taken at this edge, then dropped
  task automatic go;
    @(posedge i_mclk);
    {i_lst_wr, i_set_control_flag_op, i_clear_control_flag_op, i_arp_load, i_dp_load, i_pm_load, i_c_load,
     i_arith_add, i_arith_sub, i_alu_ovf, i_ov_clear, i_bit_test,
     i_aux_compare, i_acc_scale_detect_op_step, i_int_trap} <= '0;
    #1;
  endtask

  task automatic flag(input logic s, input logic [2:0] f);
    @(posedge i_mclk);
    i_set_control_flag_op <= s;
    i_clear_control_flag_op <= !s;
    i_flag_sel <= f;
    go;
  endtask

  task automatic ld(input logic sel, input logic [15:0] d);
    @(posedge i_mclk);
    i_lst_wr <= 1'b1;
    i_lst_sel <= sel;
    i_lst_data <= d;
    go;
  endtask

  task automatic t_reset;
    @(posedge i_mclk);
    i_int_pending <= 1'b1;
    go;
    chk("word0", 16'h0600, o_status_word_zero);
    chk("word1", 16'h07fc, o_status_word_one);
    chk("xf", 1'h1, o_external_flag_out);
    chk("grant", 1'h0, o_maskable_grant);
  endtask

  task automatic t_setclr;
    logic [15:0] w0, w1;
    int wd[8] = '{1, 1, 0, 0, 1, 1, 1, 2};
    int bt[8] = '{9, 12, 9, 11, 10, 11, 4, 0};
    for (int f = 0; f < 8; f++)
    begin
      for (int s = 1; s >= 0; s--)
      begin
        w0 = o_status_word_zero;
        w1 = o_status_word_one;
        if (wd[f] == 0)
          w0[bt[f]] = s[0];
        if (wd[f] == 1)
          w1[bt[f]] = s[0];
        flag(s[0], f[2:0]);
        chk("word0", w0, o_status_word_zero);
        chk("word1", w1, o_status_word_one);
        chk("xf", w1[4], o_external_flag_out);
        chk("map", w1[12], o_ram_map_select);
      end
    end
    chk("grant", 1'h1, o_maskable_grant);
    @(posedge i_mclk);
    i_int_trap <= 1'b1;
    go;
    chk("grant", 1'h0, o_maskable_grant);
  endtask

  task automatic t_arp;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge i_mclk);
      i_arp_load <= 1'b1;
      i_arp_value <= k ? 3'h3 : 3'h5;
      go;
      chk("ptr", k ? 3'h3 : 3'h5, o_status_word_zero[15:13]);
      chk("buf", k ? 3'h5 : 3'h0, o_status_word_one[15:13]);
      chk("ptr_o", k ? 3'h3 : 3'h5, o_aux_reg_pointer);
    end
  endtask

  task automatic t_lst;
    ld(1'b0, 16'hf9ff);
    chk("word0", 16'hffff, o_status_word_zero);
    ld(1'b1, 16'h4000);
    chk("word1", 16'h41ec, o_status_word_one);
    chk("ptr", 3'h2, o_aux_reg_pointer);
    chk("xf", 1'h0, o_external_flag_out);
    ld(1'b1, 16'h1000);
    chk("map", 1'h1, o_ram_map_select);
    ld(1'b0, 16'h0000);
    chk("word0", 16'h0600, o_status_word_zero);
  endtask

  task automatic t_carry;
    logic [7:0] ad = 8'h93;
    logic [7:0] s16 = 8'hf0;
    logic [7:0] ex = 8'hb9;
    logic [7:0] af = 8'h81;
    logic [7:0] a2 = 8'h28;
    logic [7:0] b2 = 8'h44;
    for (int r = 0; r < 8; r++)
    begin
      @(posedge i_mclk);
      i_arith_add <= ad[r];
      i_arith_sub <= !ad[r];
      i_shift16 <= s16[r];
      alu_a <= af[r] ? 16'hffff : (a2[r] ? 16'h2 : 16'h1);
      alu_b <= b2[r] ? 16'h2 : 16'h1;
      go;
      chk("carry", ex[r], o_status_word_one[C_BIT]);
    end
    @(posedge i_mclk);
    i_c_load <= 1'b1;
    go;
    chk("carry", 1'h0, o_status_word_one[C_BIT]);
  endtask

  task automatic t_ov_tc;
    @(posedge i_mclk);
    i_alu_ovf <= 1'b1;
    go;
    repeat (3) @(posedge i_mclk);
    #1 chk("ov", 1'h1, o_status_word_zero[OV_BIT]);
    @(posedge i_mclk);
    i_ov_clear <= 1'b1;
    go;
    chk("ov", 1'h0, o_status_word_zero[OV_BIT]);
    for (int r = 0; r < 6; r++)
    begin
      @(posedge i_mclk);
      i_bit_test <= r < 2;
      i_aux_compare <= r / 2 == 1;
      i_acc_scale_detect_op_step <= r > 3;
      i_tested_bit <= !r[0];
      i_compare_true <= !r[0];
      i_acc_msbs <= r[0] ? 2'h3 : 2'h1;
      go;
      chk("tc", !r[0], o_status_word_one[TC_BIT]);
    end
  endtask

  task automatic t_comb;
    logic [31:0] e[4] = '{32'h80000011, 32'h22, 32'h110, 32'hfe000000};
    for (int m = 0; m < 4; m++)
    begin
      @(posedge i_mclk);
      i_pm_load <= 1'b1;
      i_pm_value <= m[1:0];
      i_product_register <= e[0];
      go;
      chk("pshift", e[m], o_product_scaled);
    end
    @(posedge i_mclk);
    i_mem_data <= 16'h8001;
    i_mem_shift <= 5'h4;
    i_dp_load <= 1'b1;
    i_dp_value <= 9'h1a5;
    i_instr_low7 <= 7'h33;
    go;
    chk("scale", 32'h00080010, o_mem_scaled);
    chk("daddr", 16'hd2b3, o_direct_addr);
    flag(1'b1, 3'h4);
    chk("scale", 32'hfff80010, o_mem_scaled);
    @(posedge i_mclk);
    i_add_no_sign_ext <= 1'b1;
    i_acc_raw <= 32'h12345678;
    i_acc_overflow <= 1'b1;
    i_acc_ovf_positive <= 1'b1;
    go;
    chk("scale", 32'h00080010, o_mem_scaled);
    chk("acc", 32'h12345678, o_acc_result);
    flag(1'b1, 3'h3);
    chk("acc", 32'h7fffffff, o_acc_result);
    @(posedge i_mclk);
    i_acc_ovf_positive <= 1'b0;
    go;
    chk("acc", 32'h80000000, o_acc_result);
  endtask

  // Mid-run reset after map, saturate and product modes, page and mask were all moved
  task automatic t_rst2;
    flag(1'b0, 3'h2);
    chk("grant", 1'h1, o_maskable_grant);
    @(posedge i_mclk);
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_resetn <= 1'b1;
    go;
    chk("word0", 16'h0600, o_status_word_zero);
    chk("word1", 16'h07fc, o_status_word_one);
    chk("grant", 1'h0, o_maskable_grant);
    chk("map", 1'h0, o_ram_map_select);
    chk("xf", 1'h1, o_external_flag_out);
    chk("pshift", 32'h80000011, o_product_scaled);
    chk("acc", 32'h12345678, o_acc_result);
  endtask

  task automatic tally_and_finish;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  initial
  begin
    #20000;
    error_cnt++;
    tally_and_finish;
  end

  initial
  begin
    {i_resetn, i_lst_wr, i_lst_sel, i_set_control_flag_op, i_clear_control_flag_op, i_arp_load, i_dp_load,
     i_pm_load, i_c_load, i_c_value, i_arith_add, i_arith_sub, i_shift16,
     i_alu_ovf, i_ov_clear, i_bit_test, i_tested_bit, i_aux_compare,
     i_compare_true, i_acc_scale_detect_op_step, i_int_pending, i_int_trap, i_acc_overflow,
     i_acc_ovf_positive, i_add_no_sign_ext, i_pm_value, i_acc_msbs,
     i_flag_sel, i_arp_value, i_mem_shift, i_instr_low7, i_dp_value,
     i_lst_data, i_mem_data, alu_a, alu_b, i_acc_raw,
     i_product_register} = '0;
    repeat (3) @(posedge i_mclk);
    i_resetn <= 1'b1;
    t_reset;
    t_setclr;
    t_arp;
    t_lst;
    t_carry;
    t_ov_tc;
    t_comb;
    t_rst2;
    tally_and_finish;
  end
endmodule
`default_nettype wire
